// ---- src/daqio_regs.sv ----
// host register window of the acquisition subsystem: converter control,
// sample store, analog output codes, digital ports, two counters
// assumes host strobes are synchronous one-cycle pulses on clk_sys
//
// Summary of operation
// - decode sixteen byte locations at a configurable base, default 280h
// - 16-bit samples from sixteen channels, stored in a 48-entry queue
// - analog interrupt when queue fill reaches programmed threshold
// - four analog output codes of 12 bits loaded through the window
// - twenty-four digital lines with software-set direction
// - 24-bit pacing counter and separate 16-bit general counter
// - offset 3 writes gain and scan, reads them with status
// - offsets 6 and 7 split analog code writes and status reads
// - offset 4 holds interrupt, transfer, counter control and reads back
// - offsets 8 to 10 port data, offset 11 direction, all readable
// - no response to host accesses while disabled by configuration
// - conversions at most 100 kHz, counter paced, externally triggered or software started
// - offset 0 bits are one-shot triggers; zero bits do nothing
// - board reset clears all but analog outputs, ports to input
`timescale 1ns/10ps
module daqio_regs
  import daqio_pkg::*;
#(
  parameter logic [7:0] REV_CODE = 8'h5a  // arbitrary value
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // host io bus
  input  daqio_io_req_t      io_req,
  output logic [7:0]         io_rdata,
  output logic               io_rdata_oe,
  // configuration
  input  wire logic          cfg_enable,
  input  wire logic [5:0]    cfg_base,
  // converter
  output logic               adc_start,
  output logic [3:0]         adc_chan,
  output logic [1:0]         adc_gain,
  input  wire logic          adc_done,
  input  wire logic [15:0]   adc_data,
  input  wire logic          ext_trig,
  // analog outputs
  output logic [3:0][11:0]   dac_code,
  output logic [3:0]         dac_update,
  // digital ports
  input  wire logic [23:0]   dio_in,
  output logic [23:0]        dio_out,
  output logic [23:0]        dio_oe,
  // interrupt request
  output logic               irq
);

  logic [3:0]    ofs;
  logic          hit, wr_hit, rd_hit, brd, cmd_wr;
  logic [7:0]    chan_q, gain_q, ctl_q, thr_q, dalo_q, dir_q;
  logic [7:0]    pa_q, pb_q, pc_q;
  logic [23:0]   ct_ld_q, ct_lat_q, ctr0_q;
  logic [15:0]   ctr1_q;
  logic          ct0_en_q, ct1_en_q, tick0, tick1;
  logic [15:0]   fifo_q [FIFO_DEPTH];
  logic [5:0]    wptr_q, rptr_q, fcnt_q;
  logic          push, pop, ovf_q;
  daqio_adc_st_t st_q;
  logic [7:0]    gap_q;
  logic [3:0]    cur_ch_q;
  logic          trig, go;
  logic [2:0]    trg_s_q, dint_s_q;
  logic [23:0]   dio_s1_q, dio_s2_q;
  logic          aint_q, tint_q, dint_q;
  logic [7:0]    rd_d;

  // address decode
  assign ofs    = io_req.addr[3:0];
  assign hit    = cfg_enable && (io_req.addr[9:4] == cfg_base);
  assign wr_hit = hit && io_req.wr;
  assign rd_hit = hit && io_req.rd;
  assign cmd_wr = wr_hit && (ofs == OFS_CMD);
  assign brd    = cmd_wr && io_req.wdata[CMD_RSTB];

  // plain control registers, all cleared by board reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_q <= 8'h00;
      gain_q <= 8'h00;
      ctl_q  <= 8'h00;
      thr_q  <= 8'h00;
      dalo_q <= 8'h00;
      dir_q  <= 8'h00;
      pa_q   <= 8'h00;
      pb_q   <= 8'h00;
      pc_q   <= 8'h00;
    end else if (brd) begin
      chan_q <= 8'h00;
      gain_q <= 8'h00;
      ctl_q  <= 8'h00;
      thr_q  <= 8'h00;
      dalo_q <= 8'h00;
      dir_q  <= 8'h00;
      pa_q   <= 8'h00;
      pb_q   <= 8'h00;
      pc_q   <= 8'h00;
    end else if (wr_hit) begin
      case (ofs)
        OFS_CHAN: chan_q <= io_req.wdata;
        OFS_GAIN: gain_q <= {5'h00, io_req.wdata[2:0]};
        OFS_CTL:  ctl_q  <= io_req.wdata;
        OFS_THR:  thr_q  <= {2'h0, io_req.wdata[5:0]};
        OFS_DALO: dalo_q <= io_req.wdata;
        OFS_PA:   pa_q   <= io_req.wdata;
        OFS_PB:   pb_q   <= io_req.wdata;
        OFS_PC:   pc_q   <= io_req.wdata;
        OFS_DIR:  dir_q  <= io_req.wdata & 8'h9b;
        default: ;
      endcase
    end
  end

  // analog output codes survive board reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dac_code   <= '0;
      dac_update <= 4'h0;
    end else begin
      dac_update <= 4'h0;
      if (cmd_wr && io_req.wdata[CMD_RSTD]) begin
        dac_code   <= '0;
        dac_update <= 4'hf;
      end else if (wr_hit && ofs == OFS_DAHI) begin
        dac_code[io_req.wdata[7:6]]   <= {io_req.wdata[3:0], dalo_q};
        dac_update[io_req.wdata[7:6]] <= 1'b1;
      end
    end
  end

  // digital pins: synchronise, then drive per direction
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dio_s1_q <= 24'h000000;
      dio_s2_q <= 24'h000000;
      dio_out  <= 24'h000000;
      dio_oe   <= 24'h000000;
    end else begin
      dio_s1_q <= dio_in;
      dio_s2_q <= dio_s1_q;
      dio_out  <= {pc_q, pb_q, pa_q};
      dio_oe   <= {{4{dir_q[DIR_CH]}}, {4{dir_q[DIR_CL]}},
                   {8{dir_q[DIR_B]}}, {8{dir_q[DIR_A]}}};
    end
  end

  // counters: 0 paces conversions, 1 is for general use
  assign tick0 = ct0_en_q && (ctr0_q == 24'h000001);
  assign tick1 = ct1_en_q && (ctr1_q == 16'h0001);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ct_ld_q  <= 24'h000000;
      ct_lat_q <= 24'h000000;
      ctr0_q   <= 24'h000000;
      ctr1_q   <= 16'h0000;
      ct0_en_q <= 1'b0;
      ct1_en_q <= 1'b0;
    end else if (brd) begin
      ct_ld_q  <= 24'h000000;
      ct_lat_q <= 24'h000000;
      ctr0_q   <= 24'h000000;
      ctr1_q   <= 16'h0000;
      ct0_en_q <= 1'b0;
      ct1_en_q <= 1'b0;
    end else begin
      if (tick0) ctr0_q <= ct_ld_q;
      else if (ct0_en_q && ctr0_q != 24'h000000) ctr0_q <= ctr0_q - 24'h000001;
      if (tick1) ctr1_q <= ct_ld_q[15:0];
      else if (ct1_en_q && ctr1_q != 16'h0000) ctr1_q <= ctr1_q - 16'h0001;
      if (wr_hit && ofs == OFS_CT0) ct_ld_q[7:0]   <= io_req.wdata;
      if (wr_hit && ofs == OFS_CT1) ct_ld_q[15:8]  <= io_req.wdata;
      if (wr_hit && ofs == OFS_CT2) ct_ld_q[23:16] <= io_req.wdata;
      if (wr_hit && ofs == OFS_CTCMD) begin
        if (!io_req.wdata[CT_NO]) begin
          if (io_req.wdata[CT_CLR])   ctr0_q   <= 24'h000000;
          if (io_req.wdata[CT_LOAD])  ctr0_q   <= ct_ld_q;
          if (io_req.wdata[CT_EN])    ct0_en_q <= 1'b1;
          if (io_req.wdata[CT_DIS])   ct0_en_q <= 1'b0;
          if (io_req.wdata[CT_LATCH]) ct_lat_q <= ctr0_q;
        end else begin
          if (io_req.wdata[CT_CLR])   ctr1_q   <= 16'h0000;
          if (io_req.wdata[CT_LOAD])  ctr1_q   <= ct_ld_q[15:0];
          if (io_req.wdata[CT_EN])    ct1_en_q <= 1'b1;
          if (io_req.wdata[CT_DIS])   ct1_en_q <= 1'b0;
          if (io_req.wdata[CT_LATCH]) ct_lat_q <= {8'h00, ctr1_q};
        end
      end
    end
  end

  // external trigger and digital interrupt pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trg_s_q  <= 3'h0;
      dint_s_q <= 3'h0;
    end else begin
      trg_s_q  <= {trg_s_q[1:0], ext_trig};
      dint_s_q <= {dint_s_q[1:0], dio_s2_q[16]};
    end
  end

  // conversion sequencer with minimum spacing
  assign trig = ctl_q[CTL_AINTE]
              ? (ctl_q[CTL_ADCLK] ? (trg_s_q[1] && !trg_s_q[2]) : tick0)
              : (cmd_wr && io_req.wdata[CMD_STRT]);
  assign go   = trig && !brd && (st_q == ADC_IDLE) && (gap_q == 8'h00);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= ADC_IDLE;
      gap_q     <= 8'h00;
      adc_start <= 1'b0;
      cur_ch_q  <= 4'h0;
    end else begin
      adc_start <= go;
      if (gap_q != 8'h00) gap_q <= gap_q - 8'h01;
      if (brd) begin
        st_q     <= ADC_IDLE;
        gap_q    <= 8'h00;
        cur_ch_q <= 4'h0;
      end else begin
        case (st_q)
          ADC_IDLE: if (go) begin
            st_q  <= ADC_CONV;
            gap_q <= 8'(ADC_GAP_CYC - 1);
          end
          ADC_CONV: if (adc_done) begin
            st_q <= ADC_IDLE;
            if (gain_q[GAIN_SCAN])
              cur_ch_q <= (cur_ch_q == chan_q[7:4]) ? chan_q[3:0]
                                                  : cur_ch_q + 4'h1;
          end
          default: st_q <= ADC_IDLE;
        endcase
        // channel write must not stall the sequencer
        if (wr_hit && ofs == OFS_CHAN) cur_ch_q <= io_req.wdata[3:0];
      end
    end
  end
  assign adc_chan = cur_ch_q;
  assign adc_gain = gain_q[1:0];

  // sample queue
  assign push = (st_q == ADC_CONV) && adc_done && !brd;
  assign pop  = rd_hit && ofs == OFS_SMPHI && fcnt_q != 6'd0;
  always_ff @(posedge clk_sys) begin
    if (push && fcnt_q != FIFO_FULL) fifo_q[wptr_q] <= adc_data;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q <= 6'd0;
      rptr_q <= 6'd0;
      fcnt_q <= 6'd0;
      ovf_q  <= 1'b0;
    end else if (brd || (cmd_wr && io_req.wdata[CMD_RSTF])) begin
      wptr_q <= 6'd0;
      rptr_q <= 6'd0;
      fcnt_q <= 6'd0;
      ovf_q  <= 1'b0;
    end else begin
      if (push && fcnt_q == FIFO_FULL) ovf_q <= 1'b1;
      if (push && fcnt_q != FIFO_FULL)
        wptr_q <= (wptr_q == FIFO_LAST) ? 6'd0 : wptr_q + 6'd1;
      if (pop) rptr_q <= (rptr_q == FIFO_LAST) ? 6'd0 : rptr_q + 6'd1;
      case ({push && fcnt_q != FIFO_FULL, pop})
        2'b10:   fcnt_q <= fcnt_q + 6'd1;
        2'b01:   fcnt_q <= fcnt_q - 6'd1;
        default: ;
      endcase
    end
  end

  // interrupt flags; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aint_q <= 1'b0;
      tint_q <= 1'b0;
      dint_q <= 1'b0;
      irq    <= 1'b0;
    end else if (brd) begin
      aint_q <= 1'b0;
      tint_q <= 1'b0;
      dint_q <= 1'b0;
      irq    <= 1'b0;
    end else begin
      if (push && fcnt_q != FIFO_FULL && ctl_q[CTL_AINTE]
          && fcnt_q + 6'd1 == thr_q[5:0])
        aint_q <= 1'b1;
      else if (cmd_wr && io_req.wdata[CMD_CLRA]) aint_q <= 1'b0;
      if (tick1 && ctl_q[CTL_TINTE]) tint_q <= 1'b1;
      else if (cmd_wr && io_req.wdata[CMD_CLRT]) tint_q <= 1'b0;
      if (dint_s_q[1] && !dint_s_q[2] && ctl_q[CTL_DINTE]) dint_q <= 1'b1;
      else if (cmd_wr && io_req.wdata[CMD_CLRD]) dint_q <= 1'b0;
      irq <= aint_q || tint_q || dint_q;
    end
  end

  // read data select
  always_comb begin
    rd_d = 8'h00;
    case (ofs)
      OFS_CMD:   rd_d = fifo_q[rptr_q][7:0];
      OFS_SMPHI: rd_d = fifo_q[rptr_q][15:8];
      OFS_CHAN:  rd_d = chan_q;
      OFS_GAIN:  rd_d = {st_q == ADC_CONV, 1'b0, gap_q != 8'h00,
                         dac_update != 4'h0, ovf_q, gain_q[2:0]};
      OFS_CTL:   rd_d = ctl_q;
      OFS_THR:   rd_d = thr_q;
      OFS_DALO:  rd_d = {2'h0, fcnt_q};
      OFS_DAHI:  rd_d = {1'b0, tint_q, dint_q, aint_q, cur_ch_q};
      OFS_PA:    rd_d = dio_s2_q[7:0];
      OFS_PB:    rd_d = dio_s2_q[15:8];
      OFS_PC:    rd_d = dio_s2_q[23:16];
      OFS_DIR:   rd_d = dir_q;
      OFS_CT0:   rd_d = ct_lat_q[7:0];
      OFS_CT1:   rd_d = ct_lat_q[15:8];
      OFS_CT2:   rd_d = ct_lat_q[23:16];
      OFS_CTCMD: rd_d = REV_CODE;
      default:   rd_d = 8'h00;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata    <= 8'h00;
      io_rdata_oe <= 1'b0;
    end else begin
      io_rdata    <= rd_hit ? rd_d : 8'h00;
      io_rdata_oe <= rd_hit;
    end
  end

  // checks
  a_read_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_hit |=> io_rdata_oe) else $error("read not answered");
  a_disabled_silent: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (io_req.rd && !cfg_enable) |=> !io_rdata_oe)
    else $error("answered while disabled");
  a_ofs1_no_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_hit && ofs == OFS_SMPHI) |=> $stable(ctl_q) && $stable(chan_q))
    else $error("offset 1 write changed state");
  a_fifo_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fcnt_q <= FIFO_FULL) else $error("queue count beyond depth");
  a_thresh_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (push && !brd && fcnt_q != FIFO_FULL && ctl_q[CTL_AINTE]
     && fcnt_q + 6'd1 == thr_q[5:0])
    |=> aint_q ##1 irq) else $error("threshold flag missing");
  a_board_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    brd |=> ctl_q == 8'h00 && dir_q == 8'h00 && fcnt_q == 6'd0
            && $stable(dac_code) ##1 dio_oe == 24'h000000)
    else $error("board reset incomplete");
  a_dac_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_hit && ofs == OFS_DAHI && !(cmd_wr))
    |=> dac_code[$past(io_req.wdata[7:6])]
        == {$past(io_req.wdata[3:0]), $past(dalo_q)})
    else $error("analog code not loaded");
  a_ctl_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_hit && ofs == OFS_CTL) |=> ctl_q == $past(io_req.wdata))
    else $error("control not held");
  a_adc_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adc_start |-> gap_q == 8'(ADC_GAP_CYC - 1))
    else $error("conversions too close");
  a_sw_oneshot: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmd_wr && !io_req.wdata[CMD_STRT] && !ctl_q[CTL_AINTE]) |=> !adc_start)
    else $error("start without trigger bit");

endmodule // daqio_regs

// ---- src/daqio_pkg.sv ----
// constants, field positions and carrier types of the acquisition register block
// assumes a single 20 MHz system clock shared by the whole block
package daqio_pkg;
  // timing
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned ADC_GAP_NS  = 10000;
  localparam int unsigned ADC_GAP_CYC = (ADC_GAP_NS + CLK_NS - 1) / CLK_NS;
  // address window
  localparam logic [9:0] BASE_DEFAULT = 10'h280;
  localparam logic [3:0] OFS_CMD    = 4'h0;
  localparam logic [3:0] OFS_SMPHI  = 4'h1;
  localparam logic [3:0] OFS_CHAN   = 4'h2;
  localparam logic [3:0] OFS_GAIN   = 4'h3;
  localparam logic [3:0] OFS_CTL    = 4'h4;
  localparam logic [3:0] OFS_THR    = 4'h5;
  localparam logic [3:0] OFS_DALO   = 4'h6;
  localparam logic [3:0] OFS_DAHI   = 4'h7;
  localparam logic [3:0] OFS_PA     = 4'h8;
  localparam logic [3:0] OFS_PB     = 4'h9;
  localparam logic [3:0] OFS_PC     = 4'ha;
  localparam logic [3:0] OFS_DIR    = 4'hb;
  localparam logic [3:0] OFS_CT0    = 4'hc;
  localparam logic [3:0] OFS_CT1    = 4'hd;
  localparam logic [3:0] OFS_CT2    = 4'he;
  localparam logic [3:0] OFS_CTCMD  = 4'hf;
  // command bits
  localparam int CMD_STRT = 7;
  localparam int CMD_RSTB = 6;
  localparam int CMD_RSTD = 5;
  localparam int CMD_RSTF = 4;
  localparam int CMD_CLRT = 2;
  localparam int CMD_CLRD = 1;
  localparam int CMD_CLRA = 0;
  // control bits
  localparam int CTL_AINTE = 0;
  localparam int CTL_DINTE = 1;
  localparam int CTL_TINTE = 2;
  localparam int CTL_ADCLK = 4;
  localparam int GAIN_SCAN = 2;
  // direction bits (1 = output)
  localparam int DIR_CL = 0;
  localparam int DIR_B  = 1;
  localparam int DIR_CH = 3;
  localparam int DIR_A  = 4;
  // counter command bits
  localparam int CT_CLR   = 0;
  localparam int CT_LOAD  = 1;
  localparam int CT_EN    = 2;
  localparam int CT_DIS   = 3;
  localparam int CT_LATCH = 6;
  localparam int CT_NO    = 7;
  // sample store
  localparam int unsigned FIFO_DEPTH = 48;
  localparam logic [5:0]  FIFO_LAST  = 6'd47;
  localparam logic [5:0]  FIFO_FULL  = 6'd48;

  typedef struct packed {
    logic [9:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } daqio_io_req_t;

  typedef enum logic [1:0] {
    ADC_IDLE = 2'b01,
    ADC_CONV = 2'b10
  } daqio_adc_st_t;
endpackage

// ---- verif/daqio_adc_model.sv ----
// converter stand-in: answers each start with one done pulse and a sample
// assumes the block samples adc_data in the cycle where adc_done is high
`timescale 1ns/10ps
module daqio_adc_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // converter side
  input  wire logic        adc_start,
  input  wire logic        slow,
  output logic             adc_done,
  output logic [15:0]      adc_data,
  output logic [15:0]      last_sample
);
  int seed = 61776;

  initial begin
    adc_done = 1'b0;
    adc_data = 16'h0;
    last_sample = 16'h0;
    forever begin
      @(posedge clk_sys);
      if (rst_n === 1'b1 && adc_start === 1'b1) begin
        repeat (slow ? 120 : 3) @(posedge clk_sys);
        @(negedge clk_sys);
        last_sample = 16'($random(seed));
        adc_data = last_sample;
        adc_done = 1'b1;
        @(negedge clk_sys);
        adc_done = 1'b0;
        // stale data is not held once the pulse is over
        adc_data = ~last_sample;
      end
    end
  end
endmodule // daqio_adc_model

// ---- verif/testbench.sv ----
// self-checking bench of the acquisition register window
// assumes the converter stand-in model and the design package
`timescale 1ns/10ps
module testbench;
  import daqio_pkg::*;
  localparam logic [7:0] REV_TB = 8'h3c; // arbitrary value
  logic                  clk_sys;
  logic                  rst_n;
  logic                  cfg_enable;
  logic                  ext_trig;
  logic                  slow;
  logic [5:0]            cfg_base;
  daqio_io_req_t         io_req;
  logic [7:0]            io_rdata;
  logic                  io_rdata_oe;
  logic                  adc_start;
  logic                  adc_done;
  logic                  irq;
  logic [3:0]            adc_chan;
  logic [3:0]            dac_update;
  logic [1:0]            adc_gain;
  logic [15:0]           adc_data;
  logic [15:0]           last_sample;
  logic [3:0][11:0]      dac_code;
  logic [3:0][11:0]      dac_exp;
  logic [23:0]           dio_in;
  logic [23:0]           dio_out;
  logic [23:0]           dio_oe;
  logic [23:0]           pexp;
  logic [7:0]            v;
  logic [7:0]            lo;
  logic                  oe;
  logic [1:0]            c;
  int                    error_cnt = 0;
  int                    checked = 0;
  int                    seed = 61776;

  daqio_regs #(.REV_CODE(REV_TB)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .io_req(io_req),
    .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe),
    .cfg_enable(cfg_enable), .cfg_base(cfg_base),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_gain(adc_gain),
    .adc_done(adc_done), .adc_data(adc_data), .ext_trig(ext_trig),
    .dac_code(dac_code), .dac_update(dac_update), .dio_in(dio_in),
    .dio_out(dio_out), .dio_oe(dio_oe), .irq(irq));

  daqio_adc_model i_adc (
    .clk_sys(clk_sys), .rst_n(rst_n), .adc_start(adc_start), .slow(slow),
    .adc_done(adc_done), .adc_data(adc_data), .last_sample(last_sample));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // drive enables seen on the port pins for a direction byte
  function automatic logic [23:0] oe_of(logic [7:0] dr);
    return {{4{dr[DIR_CH]}}, {4{dr[DIR_CL]}}, {8{dr[DIR_B]}}, {8{dr[DIR_A]}}};
  endfunction

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one strobe cycle; read data is taken in the cycle after the strobe
  task automatic bus(logic [9:0] a, logic w, logic [7:0] d,
                     output logic [7:0] q, output logic qoe);
    @(negedge clk_sys);
    io_req = '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge clk_sys);
    io_req.wr = 1'b0;
    io_req.rd = 1'b0;
    q = io_rdata;
    qoe = io_rdata_oe;
  endtask

  task automatic wr(logic [3:0] ofs, logic [7:0] d);
    logic [7:0] q;
    logic       qoe;
    bus({cfg_base, ofs}, 1'b1, d, q, qoe);
  endtask

  task automatic rchk(string nm, logic [3:0] ofs, logic [7:0] e);
    bus({cfg_base, ofs}, 1'b0, 8'h00, v, oe);
    chk("read enable", 1'b1, oe);
    chk(nm, e, v);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (adc_done !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    chk("conversion done", 1'b1, adc_done);
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    error_cnt++;
    wrap_up();
  end

  initial begin
    io_req = '0;
    cfg_enable = 1'b1;
    cfg_base = 6'h28;
    ext_trig = 1'b0;
    slow = 1'b0;
    dio_in = 24'h0;
    rst_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    for (int i = 2; i < 15; i++) rchk("reset value", 4'(i), 8'h00);
    rchk("revision", OFS_CTCMD, REV_TB);
    repeat (8) begin
      v = 8'($random(seed));
      lo = v;
      wr(OFS_CHAN, lo);
      rchk("channel select", OFS_CHAN, lo);
      chk("conversion channel", lo[3:0], adc_chan);
      wr(OFS_CTL, lo & 8'hee);
      rchk("control", OFS_CTL, lo & 8'hee);
      wr(OFS_THR, lo);
      rchk("threshold", OFS_THR, lo & 8'h3f);
      wr(OFS_GAIN, lo);
      rchk("gain", OFS_GAIN, {5'h00, lo[2:0]});
      chk("gain pins", lo[1:0], adc_gain);
      wr(OFS_DIR, lo);
      rchk("direction", OFS_DIR, lo & 8'h9b);
      chk("drive enable", oe_of(lo), dio_oe);
    end
    wr(OFS_CTL, 8'h00);
    wr(OFS_CHAN, 8'ha5);
    wr(OFS_SMPHI, 8'hff);
    rchk("after offset 1 write", OFS_CHAN, 8'ha5);
    rchk("fill after offset 1 write", OFS_DALO, 8'h00);
    bus({cfg_base + 6'h1, OFS_CHAN}, 1'b1, 8'h11, v, oe);
    bus({cfg_base + 6'h1, OFS_CHAN}, 1'b0, 8'h00, v, oe);
    chk("outside window enable", 1'b0, oe);
    cfg_enable = 1'b0;
    wr(OFS_CHAN, 8'h22);
    bus({cfg_base, OFS_CHAN}, 1'b0, 8'h00, v, oe);
    chk("disabled enable", 1'b0, oe);
    cfg_enable = 1'b1;
    cfg_base = 6'h31;
    rchk("moved base", OFS_CHAN, 8'ha5);
    wr(OFS_CHAN, 8'h00);
    wr(OFS_DIR, 8'h9b);
    for (int p = 0; p < 3; p++) begin
      v = 8'($random(seed));
      pexp[8*p +: 8] = v;
      wr(4'(OFS_PA + p), v);
    end
    // port data reaches the pins one cycle after the register
    @(negedge clk_sys);
    chk("port out", pexp, dio_out);
    wr(OFS_DIR, 8'h00);
    dio_in = 24'($random(seed));
    repeat (3) @(negedge clk_sys);
    for (int p = 0; p < 3; p++) rchk("port in", 4'(OFS_PA + p), dio_in[8*p +: 8]);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      dac_exp[i] = 12'($random(seed));
      wr(OFS_DALO, dac_exp[i][7:0]);
      wr(OFS_DAHI, {c, 2'b00, dac_exp[i][11:8]});
      chk("analog code", dac_exp[i], dac_code[i]);
      chk("analog update", 4'h1 << c, dac_update);
    end
    wr(OFS_CMD, 8'h80);
    wr(OFS_CMD, 8'h80);
    wait_done();
    rchk("fill one", OFS_DALO, 8'h01);
    bus({cfg_base, OFS_CMD}, 1'b0, 8'h00, lo, oe);
    rchk("sample high", OFS_SMPHI, last_sample[15:8]);
    chk("sample low", last_sample[7:0], lo);
    slow = 1'b1;
    repeat (210) @(negedge clk_sys);
    wr(OFS_CMD, 8'h80);
    bus({cfg_base, OFS_GAIN}, 1'b0, 8'h00, v, oe);
    chk("busy", 1'b1, v[7]);
    wait_done();
    bus({cfg_base, OFS_GAIN}, 1'b0, 8'h00, v, oe);
    chk("idle", 1'b0, v[7]);
    slow = 1'b0;
    wr(OFS_CMD, 8'h10);
    rchk("fill reset", OFS_DALO, 8'h00);
    wr(OFS_THR, 8'h02);
    wr(OFS_CTL, 8'h11);
    for (int k = 0; k < 2; k++) begin
      repeat (210) @(negedge clk_sys);
      ext_trig = 1'b1;
      repeat (3) @(negedge clk_sys);
      ext_trig = 1'b0;
      wait_done();
    end
    chk("irq at threshold", 1'b1, irq);
    rchk("flags", OFS_DAHI, 8'h10);
    wr(OFS_CMD, 8'h80);
    repeat (20) @(negedge clk_sys);
    rchk("no soft start", OFS_DALO, 8'h02);
    wr(OFS_CMD, 8'h11);
    repeat (2) @(negedge clk_sys);
    chk("irq cleared", 1'b0, irq);
    rchk("fill cleared", OFS_DALO, 8'h00);
    for (int p = 0; p < 3; p++) begin
      v = 8'($random(seed));
      pexp[8*p +: 8] = v;
      wr(4'(OFS_CT0 + p), v);
    end
    wr(OFS_CTCMD, 8'h02);
    wr(OFS_CTCMD, 8'h40);
    for (int p = 0; p < 3; p++) begin
      rchk("counter latch", 4'(OFS_CT0 + p), pexp[8*p +: 8]);
    end
    wr(OFS_CTCMD, 8'h82);
    wr(OFS_CTCMD, 8'hc0);
    rchk("counter 1 high", OFS_CT2, 8'h00);
    rchk("counter 1 low", OFS_CT0, pexp[7:0]);
    wr(OFS_DIR, 8'h9b);
    wr(OFS_CHAN, 8'h5a);
    wr(OFS_CMD, 8'h40);
    repeat (2) @(negedge clk_sys);
    chk("ports to input", 24'h0, dio_oe);
    rchk("cleared channel", OFS_CHAN, 8'h00);
    rchk("cleared control", OFS_CTL, 8'h00);
    rchk("cleared direction", OFS_DIR, 8'h00);
    rchk("cleared latch", OFS_CT0, 8'h00);
    rchk("cleared status", OFS_GAIN, 8'h00);
    for (int i = 0; i < 4; i++) begin
      chk("analog kept", dac_exp[i], dac_code[i]);
    end
    wrap_up();
  end
endmodule // testbench
